// ### logic/fcd_defs.svh
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH
`define FCD_REG_CMD 4'h8
`define FCD_REG_STATUS 4'h8
`define FCD_REG_REQ 4'h9
`define FCD_REG_MASK_SR 4'hA
`define FCD_REG_MODE 4'hB
`define FCD_REG_CLR_PTR 4'hC
`define FCD_REG_TEMP 4'hD
`define FCD_REG_MCLR 4'hD
`define FCD_REG_CLR_MASK 4'hE
`define FCD_REG_MASK_ALL 4'hF
`define FCD_CMD_MEM2MEM 0
`define FCD_CMD_CH0_HOLD 1
`define FCD_CMD_COMPRESS 3
`define FCD_CMD_ROTATE 4
`define FCD_MODE_AUTO 2
`define FCD_MODE_DEC 3
`define FCD_MASK_RESET 4'hF
`define FCD_ADDR_CARRY_BIT 8
`endif

// ### logic/fcd_pkg.sv
package fcd_pkg;
	typedef enum logic [1:0] {FCD_XFER_VERIFY, FCD_XFER_WRITE, FCD_XFER_READ, FCD_XFER_ILLEGAL} fcd_xfer_t;
	typedef enum logic [1:0] {FCD_MODE_DEMAND, FCD_MODE_SINGLE, FCD_MODE_BLOCK, FCD_MODE_CASCADE} fcd_mode_t;
	typedef enum logic [3:0] {
		FCD_S_IDLE, FCD_S_HOLD, FCD_S_LATCH, FCD_S_ADDR, FCD_S_EXT, FCD_S_WAIT, FCD_S_STROBE
	} fcd_state_t;
endpackage : fcd_pkg

// ### logic/fcd_priority.sv
`timescale 1ns/100ps
`include "fcd_defs.svh"
module fcd_priority import fcd_pkg::*; #(
	parameter int CHANNELS = 4
) (
	input wire logic [CHANNELS-1:0] i_pending,
	input wire logic i_rotate,
	input wire logic [1:0] i_last,
	output logic o_any,
	output logic [1:0] o_winner
);
	// ==========================================
	// Priority encoder.
	always_comb begin
		logic [2:0] idx;
		o_any = 1'b0;
		o_winner = 2'h0;
		idx = 3'h0;
		for (int k = CHANNELS - 1; k >= 0; k--) begin
			if (i_rotate) begin
				idx = 3'(({1'b0, i_last} + 3'(k) + 3'h1) & 3'h3);
			end else begin
				idx = 3'(k);
			end
			if (i_pending[idx[1:0]]) begin
				o_any = 1'b1;
				o_winner = idx[1:0];
			end
		end
	end
endmodule : fcd_priority

// ### logic/fcd_controller.sv
`timescale 1ns/100ps
`include "fcd_defs.svh"
module fcd_controller import fcd_pkg::*; #(
	parameter int CHANNELS = 4
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_ior_n,
	input wire logic i_iow_n,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_data,
	input wire logic [CHANNELS-1:0] i_channel_request,
	input wire logic i_bus_hold_grant,
	input wire logic i_ready,
	input wire logic i_end_of_process_n,
	input wire logic [7:0] i_mem_data,
	output logic [7:0] o_data,
	output logic o_data_oe,
	output logic [7:0] o_addr_low,
	output logic o_addr_oe,
	output logic o_bus_hold_request,
	output logic [CHANNELS-1:0] o_channel_acknowledge,
	output logic o_io_read_strobe_n,
	output logic o_io_write_strobe_n,
	output logic o_memory_read_strobe_n,
	output logic o_memory_write_strobe_n,
	output logic o_strobe_oe,
	output logic o_end_of_process_n,
	output logic o_end_of_process_oe,
	output logic o_upper_address_latch_strobe,
	output logic o_upper_address_drive_enable,
	output logic o_terminal_count,
	output logic o_wait_state
);
	// ==========================================
	// Pin synchronisers.
	logic [CHANNELS-1:0] req_s1_q, req_s2_q;
	logic cs_s1_q, cs_s2_q, ior_s1_q, ior_s2_q, iow_s1_q, iow_s2_q, rdy_s1_q, rdy_s2_q;
	logic grant_s1_q, grant_s2_q, eop_s1_q, eop_s2_q;
	logic [3:0] addr_s1_q, addr_s2_q;
	logic [7:0] data_s1_q, data_s2_q;
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			req_s1_q <= '0;
			req_s2_q <= '0;
			{cs_s1_q, cs_s2_q, ior_s1_q, ior_s2_q, iow_s1_q, iow_s2_q} <= 6'h3F;
			{rdy_s1_q, rdy_s2_q, grant_s1_q, grant_s2_q, eop_s1_q, eop_s2_q} <= 6'h33;
			addr_s1_q <= 4'h0;
			addr_s2_q <= 4'h0;
			data_s1_q <= 8'h00;
			data_s2_q <= 8'h00;
		end else begin
			req_s1_q <= i_channel_request;
			req_s2_q <= req_s1_q;
			{cs_s1_q, ior_s1_q, iow_s1_q, rdy_s1_q} <= {i_cs_n, i_ior_n, i_iow_n, i_ready};
			{cs_s2_q, ior_s2_q, iow_s2_q, rdy_s2_q} <= {cs_s1_q, ior_s1_q, iow_s1_q, rdy_s1_q};
			{grant_s1_q, eop_s1_q} <= {i_bus_hold_grant, i_end_of_process_n};
			{grant_s2_q, eop_s2_q} <= {grant_s1_q, eop_s1_q};
			addr_s1_q <= i_addr;
			addr_s2_q <= addr_s1_q;
			data_s1_q <= i_data;
			data_s2_q <= data_s1_q;
		end
	end

	// ==========================================
	// Programming access decode.
	fcd_state_t state_q;
	logic iow_d1_q, ior_d1_q, ptr_q;
	logic prog, wr_pulse, rd_pulse, mclr, chan_reg;
	logic [15:0] base_addr_q [CHANNELS], cur_addr_q [CHANNELS], base_cnt_q [CHANNELS], cur_cnt_q [CHANNELS];
	logic [5:0] mode_q [CHANNELS];
	logic [7:0] cmd_q, temp_q;
	logic [CHANNELS-1:0] mask_q, sreq_q, tc_q;
	logic [1:0] act_q, last_q;
	logic phase_q, eop_out_q;
	assign prog = !cs_s2_q && !o_bus_hold_request && state_q == FCD_S_IDLE;
	assign wr_pulse = prog && !iow_s2_q && iow_d1_q && ior_s2_q;
	assign rd_pulse = prog && !ior_s2_q && ior_d1_q && iow_s2_q;
	assign mclr = wr_pulse && i_addr_is(`FCD_REG_MCLR);
	assign chan_reg = !addr_s2_q[3];
	function automatic logic i_addr_is(input logic [3:0] a);
		i_addr_is = addr_s2_q == a;
	endfunction : i_addr_is
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			iow_d1_q <= 1'b1;
			ior_d1_q <= 1'b1;
		end else begin
			iow_d1_q <= iow_s2_q;
			ior_d1_q <= ior_s2_q;
		end
	end

	// Byte pointer.
	always_ff @(posedge i_clock) begin
		if (i_rst || mclr || (wr_pulse && i_addr_is(`FCD_REG_CLR_PTR))) begin
			ptr_q <= 1'b0;
		end else if ((wr_pulse || rd_pulse) && chan_reg) begin
			ptr_q <= !ptr_q;
		end
	end

	// ==========================================
	// Transfer events.
	logic xfer_done, ext_eop, tc_hit, end_svc, m2m, rd_half, ch0_hold;
	logic [15:0] step_addr, cur_a;
	logic [1:0] addr_ch, cnt_ch;
	fcd_mode_t act_mode;
	fcd_xfer_t act_xfer;
	assign m2m = cmd_q[`FCD_CMD_MEM2MEM] && act_q == 2'h0 && sreq_q[0];
	assign ch0_hold = cmd_q[`FCD_CMD_CH0_HOLD];
	assign rd_half = m2m && !phase_q;
	assign addr_ch = m2m ? (phase_q ? 2'h1 : 2'h0) : act_q;
	assign cnt_ch = m2m ? 2'h1 : act_q;
	assign act_mode = fcd_mode_t'(mode_q[act_q][5:4]);
	assign act_xfer = fcd_xfer_t'(mode_q[act_q][1:0]);
	assign cur_a = cur_addr_q[addr_ch];
	assign step_addr = mode_q[addr_ch][`FCD_MODE_DEC] ? cur_a - 16'h0001 : cur_a + 16'h0001;
	assign xfer_done = state_q == FCD_S_STROBE && (!m2m || phase_q);
	assign ext_eop = !eop_s2_q && state_q != FCD_S_IDLE && state_q != FCD_S_HOLD;
	assign tc_hit = xfer_done && cur_cnt_q[cnt_ch] == 16'h0000;
	assign end_svc = tc_hit || ext_eop;

	// ==========================================
	// Channel registers.
	for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
		logic addr_step, cnt_step, auto_ld, sel;
		assign sel = chan_reg && addr_s2_q[2:1] == 2'(c);
		assign addr_step = state_q == FCD_S_STROBE && addr_ch == 2'(c) && !(m2m && c == 0 && ch0_hold);
		assign cnt_step = xfer_done && cnt_ch == 2'(c) && !tc_hit;
		assign auto_ld = end_svc && (act_q == 2'(c) || (m2m && c == 1)) && mode_q[c][`FCD_MODE_AUTO];
		always_ff @(posedge i_clock) begin
			if (i_rst) begin
				base_addr_q[c] <= 16'h0000;
				cur_addr_q[c] <= 16'h0000;
				base_cnt_q[c] <= 16'h0000;
				cur_cnt_q[c] <= 16'h0000;
				mode_q[c] <= 6'h00;
			end else begin
				if (auto_ld) begin
					cur_addr_q[c] <= base_addr_q[c];
					cur_cnt_q[c] <= base_cnt_q[c];
				end else begin
					if (addr_step) begin
						cur_addr_q[c] <= step_addr;
					end
					if (cnt_step) begin
						cur_cnt_q[c] <= cur_cnt_q[c] - 16'h0001;
					end
				end
				if (wr_pulse && sel && !addr_s2_q[0]) begin
					if (ptr_q) begin
						base_addr_q[c][15:8] <= data_s2_q;
						cur_addr_q[c][15:8] <= data_s2_q;
					end else begin
						base_addr_q[c][7:0] <= data_s2_q;
						cur_addr_q[c][7:0] <= data_s2_q;
					end
				end
				if (wr_pulse && sel && addr_s2_q[0]) begin
					if (ptr_q) begin
						base_cnt_q[c][15:8] <= data_s2_q;
						cur_cnt_q[c][15:8] <= data_s2_q;
					end else begin
						base_cnt_q[c][7:0] <= data_s2_q;
						cur_cnt_q[c][7:0] <= data_s2_q;
					end
				end
				if (wr_pulse && i_addr_is(`FCD_REG_MODE) && data_s2_q[1:0] == 2'(c)) begin
					mode_q[c] <= {data_s2_q[7:6], data_s2_q[5:4], data_s2_q[3:2]};
				end
			end
		end
	end

	// ==========================================
	// Command, mask, request and status bits.
	always_ff @(posedge i_clock) begin
		if (i_rst || mclr) begin
			cmd_q <= 8'h00;
			mask_q <= `FCD_MASK_RESET;
			sreq_q <= '0;
			tc_q <= '0;
		end else begin
			if (wr_pulse && i_addr_is(`FCD_REG_CMD)) begin
				cmd_q <= data_s2_q;
			end
			if (wr_pulse && i_addr_is(`FCD_REG_MASK_SR)) begin
				mask_q[data_s2_q[1:0]] <= data_s2_q[2];
			end else if (wr_pulse && i_addr_is(`FCD_REG_MASK_ALL)) begin
				mask_q <= data_s2_q[3:0];
			end else if (wr_pulse && i_addr_is(`FCD_REG_CLR_MASK)) begin
				mask_q <= '0;
			end else if (end_svc && !mode_q[act_q][`FCD_MODE_AUTO]) begin
				mask_q[act_q] <= 1'b1;
			end
			if (wr_pulse && i_addr_is(`FCD_REG_REQ)) begin
				sreq_q[data_s2_q[1:0]] <= data_s2_q[2];
			end else if (end_svc) begin
				sreq_q[act_q] <= 1'b0;
			end
			if (end_svc) begin
				tc_q[cnt_ch] <= 1'b1;
			end else if (rd_pulse && i_addr_is(`FCD_REG_STATUS)) begin
				tc_q <= '0;
			end
		end
	end

	// ==========================================
	// Arbitration.
	logic [CHANNELS-1:0] pending;
	logic any_req;
	logic [1:0] winner;
	assign pending = (req_s2_q & ~mask_q) | sreq_q;
	fcd_priority #(.CHANNELS(CHANNELS)) u_priority (
		.i_pending(pending),
		.i_rotate(cmd_q[`FCD_CMD_ROTATE]),
		.i_last(last_q),
		.o_any(any_req),
		.o_winner(winner)
	);

	// ==========================================
	// Sequencer.
	logic carry;
	assign carry = step_addr[`FCD_ADDR_CARRY_BIT] != cur_a[`FCD_ADDR_CARRY_BIT];
	always_ff @(posedge i_clock) begin
		if (i_rst || mclr) begin
			state_q <= FCD_S_IDLE;
			act_q <= 2'h0;
			last_q <= 2'h3;
			phase_q <= 1'b0;
			temp_q <= 8'h00;
		end else begin
			unique case (state_q)
				FCD_S_IDLE: begin
					if (any_req && !grant_s2_q) begin
						state_q <= FCD_S_HOLD;
						act_q <= winner;
					end
				end
				FCD_S_HOLD: begin
					phase_q <= 1'b0;
					if (grant_s2_q) begin
						state_q <= FCD_S_LATCH;
					end
				end
				FCD_S_LATCH: begin
					state_q <= FCD_S_ADDR;
				end
				FCD_S_ADDR: begin
					if (!cmd_q[`FCD_CMD_COMPRESS] || m2m) begin
						state_q <= FCD_S_EXT;
					end else if (!rdy_s2_q) begin
						state_q <= FCD_S_WAIT;
					end else begin
						state_q <= FCD_S_STROBE;
					end
				end
				FCD_S_EXT: begin
					state_q <= rdy_s2_q ? FCD_S_STROBE : FCD_S_WAIT;
				end
				FCD_S_WAIT: begin
					if (rdy_s2_q) begin
						state_q <= FCD_S_STROBE;
					end
				end
				FCD_S_STROBE: begin
					if (rd_half) begin
						temp_q <= i_mem_data;
						phase_q <= 1'b1;
						state_q <= carry ? FCD_S_LATCH : FCD_S_ADDR;
					end else begin
						phase_q <= 1'b0;
						if (end_svc || act_mode == FCD_MODE_SINGLE || act_mode == FCD_MODE_CASCADE ||
							(act_mode == FCD_MODE_DEMAND && !req_s2_q[act_q] && !m2m)) begin
							state_q <= FCD_S_IDLE;
							last_q <= act_q;
						end else begin
							state_q <= carry ? FCD_S_LATCH : FCD_S_ADDR;
						end
					end
				end
				default: begin
					state_q <= FCD_S_IDLE;
				end
			endcase
			if (ext_eop && state_q != FCD_S_STROBE) begin
				state_q <= FCD_S_IDLE;
				last_q <= act_q;
			end
		end
	end

	// ==========================================
	// Output registers.
	logic working, strobe_on;
	assign working = state_q != FCD_S_IDLE && state_q != FCD_S_HOLD;
	assign strobe_on = state_q == FCD_S_STROBE || state_q == FCD_S_WAIT ||
		(state_q == FCD_S_EXT && !cmd_q[`FCD_CMD_COMPRESS]);
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_data <= 8'h00;
			eop_out_q <= 1'b0;
		end else begin
			if (rd_pulse) begin
				unique case (addr_s2_q)
					`FCD_REG_STATUS: o_data <= {req_s2_q, tc_q};
					`FCD_REG_TEMP: o_data <= temp_q;
					default: o_data <= addr_s2_q[0] ? (ptr_q ? cur_cnt_q[addr_s2_q[2:1]][15:8] :
						cur_cnt_q[addr_s2_q[2:1]][7:0]) : (ptr_q ? cur_addr_q[addr_s2_q[2:1]][15:8] :
						cur_addr_q[addr_s2_q[2:1]][7:0]);
				endcase
			end else if (state_q == FCD_S_HOLD && grant_s2_q) begin
				o_data <= cur_a[15:8];
			end else if (state_q == FCD_S_STROBE && carry && !m2m) begin
				o_data <= step_addr[15:8];
			end else if (m2m && phase_q) begin
				o_data <= temp_q;
			end
			eop_out_q <= tc_hit;
		end
	end

	assign o_data_oe = (!ior_s2_q && !cs_s2_q && prog) || (working && (state_q == FCD_S_LATCH || (m2m && phase_q)));
	assign o_addr_low = cur_a[7:0];
	assign o_addr_oe = working;
	assign o_bus_hold_request = state_q != FCD_S_IDLE;
	assign o_channel_acknowledge = working && !m2m ? CHANNELS'(1) << act_q : '0;
	assign o_io_read_strobe_n = !(strobe_on && !m2m && act_xfer == FCD_XFER_WRITE);
	assign o_io_write_strobe_n = !(strobe_on && !m2m && act_xfer == FCD_XFER_READ);
	assign o_memory_read_strobe_n = !(strobe_on && (m2m ? !phase_q : act_xfer == FCD_XFER_READ));
	assign o_memory_write_strobe_n = !(strobe_on && (m2m ? phase_q : act_xfer == FCD_XFER_WRITE));
	assign o_strobe_oe = working;
	assign o_end_of_process_n = !eop_out_q;
	assign o_end_of_process_oe = eop_out_q;
	assign o_upper_address_latch_strobe = state_q == FCD_S_LATCH;
	assign o_upper_address_drive_enable = working;
	assign o_terminal_count = eop_out_q;
	assign o_wait_state = state_q == FCD_S_WAIT;
endmodule : fcd_controller

// ### tb/fcd_controller_asserts.sv
`timescale 1ns/100ps
module fcd_controller_asserts #(
	parameter int CHANNELS = 4
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic o_data_oe,
	input wire logic o_bus_hold_request,
	input wire logic [CHANNELS-1:0] o_channel_acknowledge,
	input wire logic o_io_read_strobe_n,
	input wire logic o_io_write_strobe_n,
	input wire logic o_memory_read_strobe_n,
	input wire logic o_memory_write_strobe_n,
	input wire logic o_strobe_oe,
	input wire logic o_end_of_process_n,
	input wire logic o_end_of_process_oe,
	input wire logic o_upper_address_latch_strobe,
	input wire logic o_upper_address_drive_enable,
	input wire logic o_terminal_count,
	input wire logic o_wait_state
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// ==========
	// Assertions.
	idle_quiet_a: assert property (!o_bus_hold_request |-> o_channel_acknowledge == 0 && o_io_read_strobe_n
		&& o_io_write_strobe_n && o_memory_read_strobe_n && o_memory_write_strobe_n) else $error("bus used without hold");
	hold_first_a: assert property ($rose(o_bus_hold_request) |-> !o_upper_address_latch_strobe && o_channel_acknowledge == 0)
		else $error("service began without waiting for grant");
	ack_onehot_a: assert property ($onehot0(o_channel_acknowledge)) else $error("several channels acknowledged");
	ack_working_a: assert property (o_channel_acknowledge != 0 |-> o_bus_hold_request && o_upper_address_drive_enable)
		else $error("acknowledge outside working states");
	io_excl_a: assert property (!(!o_io_read_strobe_n && !o_io_write_strobe_n)) else $error("both io strobes low");
	mem_excl_a: assert property (!(!o_memory_read_strobe_n && !o_memory_write_strobe_n)) else $error("both memory strobes low");
	wait_hold_a: assert property (o_wait_state |-> o_strobe_oe && o_bus_hold_request) else $error("wait outside transfer");
	latch_drive_a: assert property (o_upper_address_latch_strobe |-> o_data_oe ##1 !o_upper_address_latch_strobe)
		else $error("upper address latch state malformed");
	tc_eop_a: assert property (o_terminal_count |-> !o_end_of_process_n && o_end_of_process_oe)
		else $error("terminal count without end of process");
	eop_pulse_a: assert property ($fell(o_end_of_process_n) |=> o_end_of_process_n) else $error("end pulse too long");
	tc_cov: cover property (o_terminal_count);
	wait_cov: cover property (o_wait_state);
	latch_cov: cover property (o_upper_address_latch_strobe);
endmodule : fcd_controller_asserts

// ### tb/fcd_host_model.sv
`timescale 1ns/100ps
module fcd_host_model (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_hold_request,
	input wire logic i_slow,
	output logic o_grant,
	output logic o_ready,
	output logic [7:0] o_mem_data
);
	logic hold_q;
	logic [2:0] cnt_q;
	// ==========
	// Grant follows hold request and is withdrawn when it drops.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			hold_q <= 1'b0;
			o_grant <= 1'b0;
		end else begin
			hold_q <= i_hold_request;
			o_grant <= hold_q && i_hold_request;
		end
	end
	always_ff @(posedge i_clock) begin
		cnt_q <= (i_rst || !i_hold_request) ? 3'h0 : cnt_q + 3'h1;
		o_mem_data <= i_rst ? 8'h5a : o_mem_data + 8'h3b;
	end
	assign o_ready = !i_slow || cnt_q == 3'h7;
endmodule : fcd_host_model

// ### tb/fcd_controller_test.sv
`timescale 1ns/100ps
module fcd_controller_test;
	logic i_clock = 0, i_rst = 1, cs_n = 1, ior_n = 1, iow_n = 1, slow = 0, eop_n = 1, grant, ready, bus_hold_request, tc, latch, wt;
	logic memory_read_strobe_n_n, memory_write_strobe_n_n, rd_n, wr_n, bus_hold_request_prev = 0;
	logic [3:0] addr = '0, req = '0, ack, first_ack;
	logic [7:0] data = '0, o_data, mem_data, d;
	int fail_count = 0, checks_done = 0, n_latch, n_tc, n_memory_read_strobe_n, n_memory_write_strobe_n, n_ior, n_iow, n_wait, n_hrise;
	always #2.5 i_clock = ~i_clock;
	fcd_host_model i_fcd_host_model (.i_clock(i_clock), .i_rst(i_rst), .i_hold_request(bus_hold_request), .i_slow(slow),
		.o_grant(grant), .o_ready(ready), .o_mem_data(mem_data));
	fcd_controller #(.CHANNELS(4)) i_fcd_controller (.i_clock(i_clock), .i_rst(i_rst), .i_cs_n(cs_n), .i_ior_n(ior_n),
		.i_iow_n(iow_n), .i_addr(addr), .i_data(data), .i_channel_request(req), .i_bus_hold_grant(grant),
		.i_ready(ready), .i_end_of_process_n(eop_n), .i_mem_data(mem_data), .o_data(o_data), .o_data_oe(),
		.o_addr_low(), .o_addr_oe(), .o_bus_hold_request(bus_hold_request), .o_channel_acknowledge(ack),
		.o_io_read_strobe_n(rd_n), .o_io_write_strobe_n(wr_n), .o_memory_read_strobe_n(memory_read_strobe_n_n),
		.o_memory_write_strobe_n(memory_write_strobe_n_n), .o_strobe_oe(), .o_end_of_process_n(), .o_end_of_process_oe(),
		.o_upper_address_latch_strobe(latch), .o_upper_address_drive_enable(), .o_terminal_count(tc),
		.o_wait_state(wt));
	// ==========
	// Monitor.
	always @(posedge i_clock) begin
		n_latch += (latch === 1'b1);
		n_tc += (tc === 1'b1);
		n_wait += (wt === 1'b1);
		n_memory_read_strobe_n += (memory_read_strobe_n_n === 1'b0);
		n_memory_write_strobe_n += (memory_write_strobe_n_n === 1'b0);
		n_ior += (rd_n === 1'b0);
		n_iow += (wr_n === 1'b0);
		n_hrise += (bus_hold_request === 1'b1 && !bus_hold_request_prev);
		bus_hold_request_prev <= (bus_hold_request === 1'b1);
		if (ack !== 4'h0 && first_ack === 4'h0) first_ack <= ack;
	end
	task chk(input bit ok, input string m);
		checks_done++;
		if (!ok) begin
			fail_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(negedge i_clock) {addr, data, cs_n, iow_n} = {a, v, 2'b00};
		repeat (4) @(negedge i_clock);
		{cs_n, iow_n} = 2'b11;
		repeat (4) @(negedge i_clock);
	endtask : wr
	task rd(input logic [3:0] a, output logic [7:0] v);
		@(negedge i_clock) {addr, cs_n, ior_n} = {a, 2'b00};
		repeat (5) @(negedge i_clock);
		v = o_data;
		{cs_n, ior_n} = 2'b11;
		repeat (4) @(negedge i_clock);
	endtask : rd
	task prog(input int ch, input logic [15:0] a, input logic [15:0] c, input logic [7:0] m);
		wr(4'hc, 8'h00);
		wr(4'(2 * ch), a[7:0]);
		wr(4'(2 * ch), a[15:8]);
		wr(4'(2 * ch + 1), c[7:0]);
		wr(4'(2 * ch + 1), c[15:8]);
		wr(4'hb, m);
		wr(4'ha, 8'(ch));
	endtask : prog
	task zero_counts;
		{n_latch, n_tc, n_wait, n_memory_read_strobe_n, n_memory_write_strobe_n, n_ior, n_iow, n_hrise} = '0;
		first_ack = '0;
	endtask : zero_counts
	task serve(input logic [3:0] m);
		zero_counts();
		@(negedge i_clock) req = m;
		for (int i = 0; i < 200 && ack === 4'h0; i++) @(negedge i_clock);
		req = '0;
		for (int i = 0; i < 400 && (n_tc == 0 || bus_hold_request !== 1'b0); i++) @(negedge i_clock);
		chk(n_tc == 1, "terminal count not seen once");
	endtask : serve
	// ==========
	// Scenarios.
	task t_pointer;
		prog(0, 16'h1234, 16'h0000, 8'h40);
		wr(4'hc, 8'h55);
		rd(4'h0, d);
		chk(d === 8'h34, "low address byte");
		rd(4'h0, d);
		chk(d === 8'h12, "high address byte");
	endtask : t_pointer
	task t_types;
		for (int t = 0; t < 3; t++) begin
			prog(2, 16'h0040, 16'h0000, 8'h42 | 8'(t << 2));
			serve(4'b0100);
			chk(first_ack === 4'b0100 && n_wait == 0, "acknowledge or wait");
			chk(n_hrise == 1 && n_latch == 1, "single transfer service");
			case (t)
				0: chk(n_memory_read_strobe_n + n_memory_write_strobe_n + n_ior + n_iow == 0, "verify strobes");
				1: chk(n_memory_write_strobe_n > 0 && n_ior == n_memory_write_strobe_n && n_memory_read_strobe_n + n_iow == 0, "write strobes");
				default: chk(n_memory_read_strobe_n > 0 && n_iow == n_memory_read_strobe_n && n_memory_write_strobe_n + n_ior == 0, "read strobes");
			endcase
		end
	endtask : t_types
	task t_wait;
		slow = 1;
		prog(2, 16'h0040, 16'h0000, 8'h46);
		serve(4'b0100);
		chk(n_wait > 0 && n_memory_write_strobe_n > 0, "no wait states");
		slow = 0;
	endtask : t_wait
	task t_block;
		rd(4'h8, d);
		prog(1, 16'h00fe, 16'h0002, 8'h89);
		serve(4'b0010);
		chk(n_hrise == 1 && n_memory_read_strobe_n > 0 && n_iow == n_memory_read_strobe_n, "block service");
		chk(n_latch == 2, "upper latch count");
		rd(4'h8, d);
		chk(d === 8'h02, "status after block");
		@(negedge i_clock) req = 4'b0010;
		repeat (30) @(negedge i_clock);
		chk(bus_hold_request === 1'b0, "masked channel raised hold");
		req = '0;
	endtask : t_block
	task t_priority;
		prog(0, 16'h0010, 16'h0000, 8'h40);
		prog(3, 16'h0020, 16'h0000, 8'h43);
		serve(4'b1001);
		chk(first_ack === 4'b0001, "fixed priority winner");
		wr(4'h8, 8'h10);
		prog(0, 16'h0010, 16'h0000, 8'h40);
		prog(3, 16'h0020, 16'h0000, 8'h43);
		serve(4'b1001);
		chk(first_ack === 4'b1000, "rotating priority winner");
		wr(4'h8, 8'h00);
	endtask : t_priority
	task t_compress;
		wr(4'h8, 8'h08);
		prog(3, 16'h0103, 16'h0003, 8'hbb);
		rd(4'h8, d);
		serve(4'b1000);
		chk(n_memory_read_strobe_n == 4 && n_iow == 4 && n_latch == 1, "compressed transfers");
		wr(4'hc, 8'h00);
		rd(4'h6, d);
		chk(d === 8'h03, "address not reloaded");
		rd(4'h8, d);
		chk(d === 8'h08, "status after reload");
		serve(4'b1000);
		chk(n_hrise == 1 && n_memory_read_strobe_n == 4, "reloaded channel did not rerun");
		wr(4'ha, 8'h07);
		wr(4'h8, 8'h00);
	endtask : t_compress
	task t_demand;
		prog(2, 16'h0200, 16'h00ff, 8'h0a);
		zero_counts();
		@(negedge i_clock) req = 4'b0100;
		repeat (40) @(negedge i_clock);
		req = '0;
		for (int i = 0; i < 40 && bus_hold_request !== 1'b0; i++) @(negedge i_clock);
		chk(bus_hold_request === 1'b0 && n_tc == 0 && n_memory_read_strobe_n > 0 && n_hrise == 1, "demand service");
		wr(4'hc, 8'h00);
		rd(4'h5, d);
		chk(d < 8'hff && d > 8'hf0, "demand count not kept");
		wr(4'ha, 8'h06);
	endtask : t_demand
	task t_eop;
		prog(1, 16'h0000, 16'h00ff, 8'h89);
		rd(4'h8, d);
		zero_counts();
		@(negedge i_clock) req = 4'b0010;
		for (int i = 0; i < 200 && ack === 4'h0; i++) @(negedge i_clock);
		req = '0;
		repeat (10) @(negedge i_clock);
		eop_n = 0;
		for (int i = 0; i < 20 && bus_hold_request !== 1'b0; i++) @(negedge i_clock);
		eop_n = 1;
		chk(bus_hold_request === 1'b0 && n_tc == 0 && n_memory_read_strobe_n > 0, "external end ignored");
		rd(4'h8, d);
		chk(d === 8'h02, "status after external end");
	endtask : t_eop
	task t_m2m;
		prog(0, 16'h0010, 16'h0005, 8'h80);
		prog(1, 16'h0020, 16'h0001, 8'h81);
		wr(4'h8, 8'h01);
		rd(4'h8, d);
		zero_counts();
		wr(4'h9, 8'h04);
		for (int i = 0; i < 100 && (n_tc == 0 || bus_hold_request !== 1'b0); i++) @(negedge i_clock);
		chk(n_tc == 1 && n_memory_read_strobe_n == 4 && n_memory_write_strobe_n == 4 && n_ior + n_iow == 0, "memory copy strobes");
		chk(first_ack === 4'h0, "acknowledge during memory copy");
		wr(4'hc, 8'h00);
		rd(4'h1, d);
		chk(d === 8'h05, "channel 0 count changed");
		rd(4'h8, d);
		chk(d === 8'h02, "status after memory copy");
		wr(4'h8, 8'h00);
	endtask : t_m2m
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (12) @(posedge i_clock);
		@(negedge i_clock) i_rst = 0;
		repeat (4) @(negedge i_clock);
		t_pointer();
		t_types();
		t_wait();
		t_block();
		t_priority();
		t_compress();
		t_demand();
		t_eop();
		t_m2m();
		tally_and_finish();
	end
	initial begin
		#200000;
		fail_count++;
		tally_and_finish();
	end
endmodule : fcd_controller_test
bind fcd_controller fcd_controller_asserts #(.CHANNELS(CHANNELS)) i_fcd_controller_asserts (.i_clock(i_clock),
	.i_rst(i_rst), .o_data_oe(o_data_oe), .o_bus_hold_request(o_bus_hold_request),
	.o_channel_acknowledge(o_channel_acknowledge), .o_io_read_strobe_n(o_io_read_strobe_n),
	.o_io_write_strobe_n(o_io_write_strobe_n), .o_memory_read_strobe_n(o_memory_read_strobe_n),
	.o_memory_write_strobe_n(o_memory_write_strobe_n), .o_strobe_oe(o_strobe_oe),
	.o_end_of_process_n(o_end_of_process_n), .o_end_of_process_oe(o_end_of_process_oe),
	.o_upper_address_latch_strobe(o_upper_address_latch_strobe),
	.o_upper_address_drive_enable(o_upper_address_drive_enable), .o_terminal_count(o_terminal_count),
	.o_wait_state(o_wait_state));
